// File: split_interrupt_descriptor_sched.sv
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
// Contract
// - IN bytes of microframes 0-2 stored when start bit set and frame matches
// - Complete-split mask picks microframes for IN only; hardware clears processed bits
// - Start mask 0x01, complete mask 0x04: start in uframe 0, complete in 2
// - Three-bit result per microframe, packed, microframe 7 highest
// - Result bit 0 error, bit 1 babble on IN, bit 2 underrun on OUT
// - Start-split mask: software sets bits, hardware clears them after processing
// - OUT start split sent only when mask bit set and frame number matches
// - Halt on stall; babble and error flags mirror result bits 1 and 0
// - Phase bit: zero start split, one complete split; hardware updates it
module split_interrupt_descriptor_sched #(
  parameter int unsigned UFRAME_CYCLES = split_sched_pkg::UFRAME_CYC
) (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire split_sched_pkg::link_result_t link_in,
  output split_sched_pkg::split_req_t        split_req,
  output logic                               irq
);
  import split_sched_pkg::*;

  logic                   tick;
  logic [2:0]             uf;
  logic [FRAME_W-1:0]     frame_num;

  uframe_timer #(.CYC(UFRAME_CYCLES)) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .uframe  (uf),
    .frame   (frame_num)
  );

  // Bus slave
  logic        wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  ss_mask_reg;
  logic [7:0]  cs_mask_reg;
  logic        phase_reg;
  logic [23:0] result_reg;
  logic [23:0] in_data_reg;
  logic        halt_reg;
  logic        babble_reg;
  logic        xerr_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  sched_state_t     state_reg;
  logic             match_reg;

  wire addr_phase = hsel && hready && htrans[1];
  wire rd_phase   = addr_phase && !hwrite;
  wire wr_ctrl    = wr_pend_reg && (wr_addr_reg == OFS_CTRL);
  wire wr_masks   = wr_pend_reg && (wr_addr_reg == OFS_MASKS);
  wire wr_irq_clr = wr_pend_reg && (wr_addr_reg == OFS_IRQ_CLR);
  wire wr_irq_en  = wr_pend_reg && (wr_addr_reg == OFS_IRQ_EN);

  wire [31:0] rd_mux =
    (haddr == OFS_CTRL)     ? {24'h000000, ctrl_reg} :
    (haddr == OFS_MASKS)    ? {15'h0000, phase_reg, cs_mask_reg, ss_mask_reg} :
    (haddr == OFS_RESULT)   ? {5'h00, xerr_reg, babble_reg, halt_reg, result_reg} :
    (haddr == OFS_INDATA)   ? {8'h00, in_data_reg} :
    (haddr == OFS_IRQ_STAT) ? {29'h00000000, irq_stat_reg} :
    (haddr == OFS_IRQ_EN)   ? {29'h00000000, irq_en_reg} :
                              WORD_ZERO;

  // Zero wait states, so hreadyout never drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= WORD_ZERO;
      hrdata      <= WORD_ZERO;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= addr_phase ? haddr : wr_addr_reg;
      hrdata      <= rd_phase ? rd_mux : WORD_ZERO;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  // Scheduler
  wire       active   = ctrl_reg[CTRL_ACTIVE];
  wire       dir_in   = ctrl_reg[CTRL_DIR_IN];
  wire [4:0] target   = ctrl_reg[CTRL_FRAME_LO +: FRAME_W];
  wire       in_frame = (frame_num == target);
  wire       can_go   = tick && active && !halt_reg && in_frame && (state_reg == ST_IDLE);
  // IN start bits above microframe 3 are never honoured
  wire       ss_legal = !dir_in || (uf <= IN_SS_MAX);
  wire       ss_due   = can_go && ss_mask_reg[uf] && ss_legal;
  // Complete splits only for IN; a start split in the same slot wins and the complete waits until that slot comes round again
  wire       cs_due   = can_go && dir_in && cs_mask_reg[uf] && !ss_due;

  wire       done     = link_in.done && (state_reg == ST_WAIT);
  wire       done_ss  = done && (link_in.kind == KIND_SS);
  wire       done_cs  = done && (link_in.kind == KIND_CS);
  wire [2:0] done_uf  = link_in.uframe;
  wire [7:0] done_bit = 8'h01 << done_uf;

  // Software sets, hardware clears; a set in the same cycle wins
  wire [7:0] ss_set  = wr_masks ? hwdata[7:0] : 8'h00;
  wire [7:0] cs_set  = wr_masks ? hwdata[MASK_CS_LO +: 8] : 8'h00;
  wire [7:0] ss_next = (ss_mask_reg & ~(done_ss ? done_bit : 8'h00)) | ss_set;
  wire [7:0] cs_next = (cs_mask_reg & ~(done_cs ? done_bit : 8'h00)) | cs_set;

  // Hardware phase update outranks the software clear
  wire phase_next = cs_due ? 1'b1 :
                    ss_due ? 1'b0 :
                    wr_masks ? 1'b0 : phase_reg;

  wire [2:0] result_val;
  assign result_val[ST_ERR_BIT]    = link_in.xact_err;
  assign result_val[ST_BABBLE_BIT] = link_in.babble && dir_in;
  assign result_val[ST_UNDER_BIT]  = link_in.underrun && !dir_in;

  logic [23:0] result_next;
  logic [23:0] in_data_next;
  logic [7:0]  err_vec;
  logic [7:0]  bab_vec;
  logic [2:0]  store_en;

  genvar g;
  generate
    for (g = 0; g < NUM_UFRAMES; g++) begin : g_uf
      assign result_next[g*3 +: 3] =
        (done && done_uf == 3'(g)) ? result_val : result_reg[g*3 +: 3];
      assign err_vec[g] = result_next[g*3 + ST_ERR_BIT];
      assign bab_vec[g] = result_next[g*3 + ST_BABBLE_BIT];
    end
    for (g = 0; g < IN_DATA_UF; g++) begin : g_in
      // Bytes land only while the start bit is still pending
      assign store_en[g] = (state_reg == ST_WAIT) && link_in.rx_valid && dir_in
                           && match_reg && (done_uf == 3'(g)) && ss_mask_reg[g];
      assign in_data_next[g*8 +: 8] = store_en[g] ? link_in.rx_byte : in_data_reg[g*8 +: 8];
    end
  endgenerate

  wire err_event = done && (link_in.xact_err || link_in.babble
                            || link_in.underrun || link_in.stalled);
  wire [IRQ_W-1:0] irq_ev   = {err_event, done_cs, ss_due};
  wire [IRQ_W-1:0] irq_clr  = wr_irq_clr ? hwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irq_next = (irq_stat_reg & ~irq_clr) | irq_ev;
  wire [IRQ_W-1:0] en_next  = wr_irq_en ? hwdata[IRQ_W-1:0] : irq_en_reg;

  wire halt_next = (done && link_in.stalled) || (halt_reg && !wr_ctrl);
  wire issue     = ss_due || cs_due;
  sched_state_t state_next;
  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = issue ? ST_WAIT : ST_IDLE;
      ST_WAIT: state_next = done ? ST_IDLE : ST_WAIT;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg    <= CTRL_RESET;
      ss_mask_reg <= MASK_RESET;
      cs_mask_reg <= MASK_RESET;
      phase_reg   <= 1'b0;
      state_reg   <= ST_IDLE;
      match_reg   <= 1'b0;
    end else begin
      ctrl_reg    <= wr_ctrl ? hwdata[7:0] : ctrl_reg;
      ss_mask_reg <= ss_next;
      cs_mask_reg <= cs_next;
      phase_reg   <= phase_next;
      state_reg   <= state_next;
      match_reg   <= issue ? in_frame : match_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg   <= 24'h000000;
      in_data_reg  <= 24'h000000;
      halt_reg     <= 1'b0;
      babble_reg   <= 1'b0;
      xerr_reg     <= 1'b0;
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
      irq          <= 1'b0;
    end else begin
      result_reg   <= result_next;
      in_data_reg  <= in_data_next;
      halt_reg     <= halt_next;
      babble_reg   <= |bab_vec;
      xerr_reg     <= |err_vec;
      irq_stat_reg <= irq_next;
      irq_en_reg   <= en_next;
      irq          <= |(irq_next & en_next);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      split_req <= '0;
    end else begin
      split_req.valid  <= issue;
      split_req.kind   <= ss_due ? KIND_SS : (cs_due ? KIND_CS : KIND_NONE);
      split_req.uframe <= uf;
      split_req.dir_in <= dir_in;
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ss_issue_slot: assert property (
    ss_due |=> split_req.valid && split_req.kind == KIND_SS && split_req.uframe == $past(uf))
    else $error("start split not issued in its microframe");
  a_frame_gate: assert property (
    split_req.valid |-> $past(in_frame) && $past(active))
    else $error("split issued outside the target frame");
  a_cs_in_only: assert property (
    split_req.valid && split_req.kind == KIND_CS |-> split_req.dir_in && $past(cs_mask_reg[uf]))
    else $error("complete split issued without IN or mask bit");
  a_in_ss_limit: assert property (
    split_req.valid && split_req.kind == KIND_SS && split_req.dir_in |-> split_req.uframe <= 3'h3)
    else $error("IN start split above microframe 3");
  a_mask_clear: assert property (
    done_ss && !wr_masks |=> !ss_mask_reg[$past(done_uf)])
    else $error("start mask bit not cleared after processing");
  a_result_field: assert property (
    done |=> result_reg[$past(done_uf)*3 +: 3] == $past(result_val)
             && !(result_reg[$past(done_uf)*3 + 2] && $past(dir_in)))
    else $error("microframe result not recorded");
  a_in_byte_store: assert property (
    store_en[0] |=> in_data_reg[7:0] == $past(link_in.rx_byte))
    else $error("microframe 0 IN byte not stored");
  a_halt_flag: assert property (
    done && link_in.stalled |=> halt_reg ##1 (halt_reg || $past(wr_ctrl)))
    else $error("halt flag not raised on stall");
  a_flag_mirror: assert property (
    babble_reg == |{result_reg[22], result_reg[19], result_reg[16], result_reg[13],
                    result_reg[10], result_reg[7], result_reg[4], result_reg[1]}
    && xerr_reg == |{result_reg[21], result_reg[18], result_reg[15], result_reg[12],
                     result_reg[9], result_reg[6], result_reg[3], result_reg[0]})
    else $error("result flags do not follow results");
  a_phase_track: assert property (
    cs_due |=> phase_reg [*1] ##0 split_req.kind == KIND_CS)
    else $error("phase bit not set for complete split");
  a_irq_level: assert property (
    irq == |(irq_stat_reg & irq_en_reg))
    else $error("interrupt level disagrees with status");

  // Remembers whether the latest start split sat in microframe 0
  logic ss0_seen_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ss0_seen_reg <= 1'b0;
    end else if (ss_due) begin
      ss0_seen_reg <= (uf == 3'h0);
    end
  end

  c_ss_uf0: cover property (ss0_seen_reg && cs_due && uf == 3'h2);
  c_in_store: cover property (|store_en);
  c_error: cover property (err_event);
  c_irq: cover property ($rose(irq));
endmodule // split_interrupt_descriptor_sched

// File: split_partner.sv
`timescale 1ns/10ps
module split_partner (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire split_sched_pkg::split_req_t   split_req,
  input  wire logic [3:0]                    delay,
  input  wire logic [3:0]                    fail_mode,
  input  wire logic [7:0]                    in_byte,
  output split_sched_pkg::link_result_t      link_in
);
  import split_sched_pkg::*;
  split_req_t req;
  logic [3:0] cnt;
  logic       busy;
  logic       tgl;
  logic       fire;
  logic       rxv;
  assign fire = busy && cnt == 4'h0;
  // Two bytes per IN split, so the stored byte must be the later one
  assign rxv  = busy && req.dir_in && (cnt == 4'h2 || cnt == 4'h1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
      req  <= '0;
      tgl  <= 1'b0;
    end else begin
      tgl <= ~tgl;
      if (split_req.valid) begin
        busy <= 1'b1;
        cnt  <= delay;
        req  <= split_req;
      end else if (busy) begin
        cnt  <= cnt - 4'h1;
        busy <= !fire;
      end
    end
  end
  // Outside done the outcome lines carry the inverse, except uframe, which stays true while rx_valid; never a stale copy
  always_comb begin
    link_in.done     = fire;
    link_in.kind     = fire ? req.kind : split_kind_t'(~req.kind);
    link_in.uframe   = (fire || rxv) ? req.uframe : ~req.uframe;
    link_in.xact_err = fire ? fail_mode[0] : ~fail_mode[0];
    link_in.babble   = fire ? fail_mode[1] : ~fail_mode[1];
    link_in.underrun = fire ? fail_mode[2] : ~fail_mode[2];
    link_in.stalled  = fire ? fail_mode[3] : ~fail_mode[3];
    link_in.rx_valid = rxv;
    link_in.rx_byte  = rxv ? (cnt == 4'h2 ? ~in_byte : in_byte) : {8{tgl}};
  end
endmodule // split_partner

// File: split_sched_pkg.sv
package split_sched_pkg;
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned UFRAME_NS   = 125_000;
  localparam int unsigned UFRAME_CYC  = UFRAME_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned NUM_UFRAMES = 8;
  localparam int unsigned IN_DATA_UF  = 3;
  localparam logic [2:0]  IN_SS_MAX   = 3'h3;
  localparam int unsigned FRAME_W     = 5;

  localparam logic [31:0] OFS_CTRL     = 32'h0000_0000;
  localparam logic [31:0] OFS_MASKS    = 32'h0000_0004;
  localparam logic [31:0] OFS_RESULT   = 32'h0000_0008;
  localparam logic [31:0] OFS_INDATA   = 32'h0000_000C;
  localparam logic [31:0] OFS_IRQ_STAT = 32'h0000_0010;
  localparam logic [31:0] OFS_IRQ_CLR  = 32'h0000_0014;
  localparam logic [31:0] OFS_IRQ_EN   = 32'h0000_0018;

  localparam int unsigned CTRL_ACTIVE   = 0;
  localparam int unsigned CTRL_DIR_IN   = 1;
  localparam int unsigned CTRL_FRAME_LO = 3;
  localparam int unsigned MASK_CS_LO    = 8;
  localparam int unsigned MASK_PHASE    = 16;
  localparam int unsigned RES_HALT      = 24;
  localparam int unsigned RES_BABBLE    = 25;
  localparam int unsigned RES_XERR      = 26;
  localparam int unsigned ST_ERR_BIT    = 0;
  localparam int unsigned ST_BABBLE_BIT = 1;
  localparam int unsigned ST_UNDER_BIT  = 2;
  localparam int unsigned IRQ_SS        = 0;
  localparam int unsigned IRQ_CS        = 1;
  localparam int unsigned IRQ_ERR       = 2;
  localparam int unsigned IRQ_W         = 3;

  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  MASK_RESET  = 8'h00;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_SS   = 2'b01,
    KIND_CS   = 2'b10
  } split_kind_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } sched_state_t;

  typedef struct packed {
    logic        done;
    split_kind_t kind;
    logic [2:0]  uframe;
    logic        xact_err;
    logic        babble;
    logic        underrun;
    logic        stalled;
    logic        rx_valid;
    logic [7:0]  rx_byte;
  } link_result_t;

  typedef struct packed {
    logic        valid;
    split_kind_t kind;
    logic [2:0]  uframe;
    logic        dir_in;
  } split_req_t;
endpackage

// File: tb_split_interrupt_descriptor_sched.sv
`timescale 1ns/10ps
module tb_split_interrupt_descriptor_sched;
  import split_sched_pkg::*;
  localparam int unsigned UF = 20;
  typedef struct packed {
    logic        w;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  logic         hclk;
  logic         hresetn;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  link_result_t link_in;
  split_req_t   split_req;
  logic         irq;
  logic [3:0]   delay;
  logic [3:0]   fail_mode;
  logic [7:0]   in_byte;
  logic [31:0]  rdv;
  logic [31:0]  log_q[$];
  int unsigned  cyc;
  int           err_count;
  int           compares;
  row_t         rows[9];

  always #50 hclk = ~hclk;

  split_interrupt_descriptor_sched #(.UFRAME_CYCLES(UF)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_in(link_in),
    .split_req(split_req), .irq(irq));

  split_partner u_far (
    .hclk(hclk), .hresetn(hresetn), .split_req(split_req), .delay(delay),
    .fail_mode(fail_mode), .in_byte(in_byte), .link_in(link_in));

  // Log of every request with the cycle it came in
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      if (split_req.valid === 1'b1) begin
        log_q.push_back({cyc[15:0], 10'h000, split_req.kind, split_req.uframe, split_req.dir_in});
      end
    end
  end

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, WORD_ZERO);
    chk(nm, e, rdv);
    chk("hresp", WORD_ZERO, {31'h0, hresp});
  endtask

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge hclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  initial begin
    repeat (3000) @(posedge hclk);
    err_count++;
    end_sim;
  end

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hwdata = 0; delay = 4'h2; fail_mode = 4'h0; in_byte = 8'hA5;
    rows = '{
      '{1'b0, OFS_CTRL, WORD_ZERO, {24'h0, CTRL_RESET}},
      '{1'b0, OFS_MASKS, WORD_ZERO, {24'h0, MASK_RESET}},
      '{1'b0, OFS_RESULT, WORD_ZERO, WORD_ZERO},
      '{1'b1, OFS_RESULT, 32'hFFFF_FFFF, WORD_ZERO},
      '{1'b1, OFS_INDATA, 32'hFFFF_FFFF, WORD_ZERO},
      '{1'b1, OFS_IRQ_STAT, 32'hFFFF_FFFF, WORD_ZERO},
      '{1'b1, OFS_IRQ_CLR, 32'h0000_0007, WORD_ZERO},
      '{1'b1, 32'h0000_0040, 32'hFFFF_FFFF, WORD_ZERO},
      '{1'b1, OFS_IRQ_EN, 32'h0000_0007, 32'h0000_0007}};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e, "register");
    end
    // IN transfer aimed at frame 1, start in uframe 0 and complete in uframe 2
    bus(1'b1, OFS_CTRL, 32'h0000_000B);
    bus(1'b1, OFS_MASKS, 32'h0000_0401);
    repeat (16 * UF) @(posedge hclk);
    chk("request count", 32'd2, log_q.size());
    chk("start request", {26'h0, KIND_SS, 3'h0, 1'b1}, {26'h0, log_q[0][5:0]});
    chk("complete request", {26'h0, KIND_CS, 3'h2, 1'b1}, {26'h0, log_q[1][5:0]});
    rd_chk(OFS_MASKS, 32'h0001_0000, "masks after IN");
    rd_chk(OFS_INDATA, 32'h0000_00A5, "IN byte");
    rd_chk(OFS_RESULT, WORD_ZERO, "clean result");
    rd_chk(OFS_IRQ_STAT, 32'h0000_0003, "irq status");
    irq_chk(1'b1);
    bus(1'b1, OFS_IRQ_EN, WORD_ZERO);
    irq_chk(1'b0);
    bus(1'b1, OFS_IRQ_EN, 32'h0000_0007);
    irq_chk(1'b1);
    bus(1'b1, OFS_IRQ_CLR, 32'h0000_0003);
    irq_chk(1'b0);
    rd_chk(OFS_IRQ_STAT, WORD_ZERO, "irq status cleared");
    // Reset in mid-run, then a slow OUT split in uframe 7 that fails every way
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    log_q.delete();
    delay <= 4'h9;
    fail_mode <= 4'hF;
    rd_chk(OFS_INDATA, WORD_ZERO, "IN data after reset");
    rd_chk(OFS_IRQ_EN, WORD_ZERO, "irq enable after reset");
    bus(1'b1, OFS_CTRL, 32'h0000_0009);
    bus(1'b1, OFS_IRQ_EN, 32'h0000_0007);
    bus(1'b1, OFS_MASKS, 32'h0000_0080);
    repeat (16 * UF) @(posedge hclk);
    chk("OUT count", 32'd1, log_q.size());
    chk("OUT request", {26'h0, KIND_SS, 3'h7, 1'b0}, {26'h0, log_q[0][5:0]});
    chk("OUT in frame 1", 32'd1, {31'h0, log_q[0][31:16] >= 8 * UF});
    rd_chk(OFS_RESULT, 32'h05A0_0000, "OUT result");
    rd_chk(OFS_MASKS, WORD_ZERO, "masks after OUT");
    rd_chk(OFS_IRQ_STAT, 32'h0000_0005, "error status");
    irq_chk(1'b1);
    // IN split in frame 3 uframe 1 with error and babble; CTRL write lifts the halt
    fail_mode <= 4'h3;
    bus(1'b1, OFS_CTRL, 32'h0000_001B);
    bus(1'b1, OFS_MASKS, 32'h0000_0002);
    repeat (16 * UF) @(posedge hclk);
    chk("babble count", 32'd2, log_q.size());
    chk("babble request", {26'h0, KIND_SS, 3'h1, 1'b1}, {26'h0, log_q[1][5:0]});
    rd_chk(OFS_RESULT, 32'h06A0_0018, "IN babble result");
    rd_chk(OFS_INDATA, 32'h0000_A500, "uframe1 byte");
    end_sim;
  end
endmodule // tb_split_interrupt_descriptor_sched

// File: uframe_timer.sv
`timescale 1ns/10ps
module uframe_timer #(
  parameter int unsigned CYC = split_sched_pkg::UFRAME_CYC
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  output logic            tick,
  output logic [2:0]      uframe,
  output logic [split_sched_pkg::FRAME_W-1:0] frame
);
  import split_sched_pkg::*;

  logic [15:0] cnt_reg;
  wire         wrap = (cnt_reg == 16'(CYC - 1));

  // Tick marks the first cycle of the new microframe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 16'h0000;
      tick    <= 1'b0;
      uframe  <= 3'h0;
      frame   <= '0;
    end else begin
      cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
      tick    <= wrap;
      if (wrap) begin
        uframe <= uframe + 3'h1;
        if (uframe == 3'h7) begin
          frame <= frame + FRAME_W'(1);
        end
      end
    end
  end
endmodule // uframe_timer
